// ===== src/irq_route_pkg.sv
// constants, register map and helpers for the interrupt vector router
// assumes a 32-bit avalon-mm slave with byte addresses, one clock domain
// How it works
// RL1: external pins 0..2 raise vectors 29, 30, 31; vector 29 sits at 0074h.
// RL2: second dma channel completion raises vector 41 at 00a4h.
// RL3: third dma channel request raises vector 42 at 00a8h.
// RL4: vector 43 at 00ach: serial5 start/stop, collision, consumer event 1.
// RL5: vector 44: serial5 transmit, not-acknowledge, consumer event 2.
// RL6: vector 45 at 00b4h: serial5 receive and acknowledge.
// RL7: vector 46 at 00b8h: serial6 start/stop, collision, clock period event.
// RL8: vector 47: serial6 transmit, not-acknowledge, clock compare match.
// RL9: vector 48 at 00c0h: serial6 receive and acknowledge.
// RL10: vector 49 at 00c4h: serial7 start/stop+collision, or remote control 0.
// RL11: vector 50: serial7 transmit+not-acknowledge, or remote control 1.
// RL12: vector 51 at 00cch: serial7 receive and acknowledge.
// RL13: vectors 52..58, up to 00e8h, have no hardware source at all.
// RL14: two-wire bus controller raises vector 59 at 00ech.
// RL15: two-wire clock/data pin-level event raises vector 60 at 00f0h.
// RL16: select bit 4: 0 serial7 start/stop+collision, 1 remote control 0.
// RL17: select bit 5: 0 serial7 transmit+not-acknowledge, 1 remote control 1.
// RL18: select bit 6: 0 timer b3, 1 serial0 start/stop+collision.
// RL19: select bit 7: 0 timer b4, 1 serial1 start/stop+collision.
// RL20: select bits 2 and 3 enable two-wire and pin-level sources; 0 unused.
// RL21: each vector slot is four bytes; offset equals four times number.
package irq_route_pkg;
  localparam int vec_count = 64;
  typedef logic [5:0] vec_num_type;
  typedef logic [7:0] vec_off_type;
  typedef logic [vec_count-1:0] vec_set_type;
  typedef logic [9:0] reg_index_type;

  localparam vec_num_type vec_timer_b4 = 6'h06;
  localparam vec_num_type vec_timer_b3 = 6'h07;
  localparam vec_num_type vec_ext0 = 6'h1d;
  localparam vec_num_type vec_ext1 = 6'h1e;
  localparam vec_num_type vec_ext2 = 6'h1f;
  localparam vec_num_type vec_dma2 = 6'h29;
  localparam vec_num_type vec_dma3 = 6'h2a;
  localparam vec_num_type vec_s5_cond = 6'h2b;
  localparam vec_num_type vec_s5_tx = 6'h2c;
  localparam vec_num_type vec_s5_rx = 6'h2d;
  localparam vec_num_type vec_s6_cond = 6'h2e;
  localparam vec_num_type vec_s6_tx = 6'h2f;
  localparam vec_num_type vec_s6_rx = 6'h30;
  localparam vec_num_type vec_s7_cond = 6'h31;
  localparam vec_num_type vec_s7_tx = 6'h32;
  localparam vec_num_type vec_s7_rx = 6'h33;
  localparam vec_num_type vec_soft_first = 6'h34;
  localparam vec_num_type vec_soft_last = 6'h3a;
  localparam vec_num_type vec_two_wire = 6'h3b;
  localparam vec_num_type vec_pin_level = 6'h3c;

  localparam vec_off_type off_ext0 = 8'h74;
  localparam vec_off_type off_dma2 = 8'ha4;
  localparam vec_off_type off_dma3 = 8'ha8;
  localparam vec_off_type off_s5_cond = 8'hac;
  localparam vec_off_type off_s5_rx = 8'hb4;
  localparam vec_off_type off_s6_cond = 8'hb8;
  localparam vec_off_type off_s6_rx = 8'hc0;
  localparam vec_off_type off_s7_cond = 8'hc4;
  localparam vec_off_type off_s7_rx = 8'hcc;
  localparam vec_off_type off_soft_last = 8'he8;
  localparam vec_off_type off_two_wire = 8'hec;
  localparam vec_off_type off_pin_level = 8'hf0;

  // register indices; byte address is four times the index
  localparam reg_index_type idx_select_third = 10'h205;
  localparam reg_index_type idx_select_second = 10'h206;
  localparam reg_index_type idx_select_first = 10'h207;
  localparam reg_index_type idx_match_enable = 10'h20e;
  localparam reg_index_type idx_match_enable_upper = 10'h20f;
  localparam reg_index_type idx_match_compare_0 = 10'h210;
  localparam reg_index_type idx_match_compare_1 = 10'h214;
  localparam reg_index_type idx_match_compare_2 = 10'h218;
  localparam reg_index_type idx_match_compare_3 = 10'h21c;
  localparam reg_index_type idx_pending_low = 10'h220;
  localparam reg_index_type idx_pending_high = 10'h221;

  localparam int sel_two_wire = 2;
  localparam int sel_pin_level = 3;
  localparam int sel_s7_cond = 4;
  localparam int sel_s7_tx = 5;
  localparam int sel_timer_b3 = 6;
  localparam int sel_timer_b4 = 7;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [23:0] reset_compare = 24'h000000;

  function automatic vec_off_type vec_offset(input vec_num_type n);
    return {n, 2'b00};
  endfunction

  // byte-lane merge of a write into the current register value
  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// ===== src/vector_pick_if.sv
// bundle between the router and its lowest-number pending picker
// assumes both ends run combinationally within one clock domain
`timescale 1ns/10ps
interface vector_pick_if;
  import irq_route_pkg::*;
  vec_set_type candidates;
  logic found;
  vec_num_type number;
  modport picker (input candidates, output found, output number);
  modport user (output candidates, input found, input number);
endinterface

// ===== src/vector_picker.sv
// picks the lowest-numbered pending vector from a set of candidates
// assumes candidates come from logic on the same clock
`timescale 1ns/10ps
module vector_picker (
  // candidate set in, chosen vector out
  vector_pick_if.picker pick
);
  import irq_route_pkg::*;

  always_comb begin
    pick.found = 1'b0;
    pick.number = '0;
    // scan downwards so the lowest number is left standing
    for (int i = vec_count - 1; i >= 0; i--) begin
      if (pick.candidates[i]) begin
        pick.found = 1'b1;
        pick.number = vec_num_type'(i);
      end
    end
  end
endmodule

// ===== src/irq_vector_router.sv
// interrupt vector router: peripheral events to sticky vector requests
// assumes event inputs are one-cycle pulses on clk, external pins are async
`timescale 1ns/10ps
module irq_vector_router (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm register slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // external interrupt pins, active low, asynchronous
  input wire logic [2:0] external_irq_pin_b,
  // dma events
  input wire logic dma2_done,
  input wire logic dma3_request,
  // serial channel 5
  input wire logic serial5_start_stop,
  input wire logic serial5_collision,
  input wire logic serial5_transmit,
  input wire logic serial5_not_acknowledge,
  input wire logic serial5_receive,
  input wire logic serial5_acknowledge,
  input wire logic consumer_control_event_1,
  input wire logic consumer_control_event_2,
  // serial channel 6 and real-time clock
  input wire logic serial6_start_stop,
  input wire logic serial6_collision,
  input wire logic serial6_transmit,
  input wire logic serial6_not_acknowledge,
  input wire logic serial6_receive,
  input wire logic serial6_acknowledge,
  input wire logic rtc_period,
  input wire logic rtc_compare_match,
  // serial channel 7 and remote-control receiver
  input wire logic serial7_start_stop,
  input wire logic serial7_collision,
  input wire logic serial7_transmit,
  input wire logic serial7_not_acknowledge,
  input wire logic serial7_receive,
  input wire logic serial7_acknowledge,
  input wire logic remote_control_0,
  input wire logic remote_control_1,
  // two-wire bus
  input wire logic two_wire_event,
  input wire logic two_wire_pin_level,
  // shared timer and serial 0/1 condition sources
  input wire logic timer_b3,
  input wire logic timer_b4,
  input wire logic serial0_start_stop,
  input wire logic serial0_collision,
  input wire logic serial1_start_stop,
  input wire logic serial1_collision,
  // processor core vector fetch
  output logic irq_request,
  output irq_route_pkg::vec_num_type irq_vector_number,
  output irq_route_pkg::vec_off_type irq_vector_offset,
  input wire logic irq_acknowledge
);
  import irq_route_pkg::*;

  logic [7:0] irq_source_select_third;
  logic [7:0] irq_source_select_second;
  logic [7:0] irq_source_select_first;
  logic [7:0] address_match_irq_enable;
  logic [7:0] address_match_irq_enable_upper;
  logic [23:0] address_match_compare_0;
  logic [23:0] address_match_compare_1;
  logic [23:0] address_match_compare_2;
  logic [23:0] address_match_compare_3;
  logic bus_ack;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;
  vec_set_type pending;
  vec_set_type set_vec;
  vec_set_type clr_vec;
  vec_set_type next_pending;

  vector_pick_if pick ();

  vector_picker picker_inst (
    .pick(pick.picker)
  );

  // register bus decode
  wire reg_index_type idx = address[11:2];
  wire logic bus_req = read | write;
  wire logic wr_go = write & bus_ack;
  wire logic hit_third = idx == idx_select_third;
  wire logic hit_second = idx == idx_select_second;
  wire logic hit_first = idx == idx_select_first;
  wire logic hit_en = idx == idx_match_enable;
  wire logic hit_en_up = idx == idx_match_enable_upper;
  wire logic hit_cmp0 = idx == idx_match_compare_0;
  wire logic hit_cmp1 = idx == idx_match_compare_1;
  wire logic hit_cmp2 = idx == idx_match_compare_2;
  wire logic hit_cmp3 = idx == idx_match_compare_3;
  wire logic hit_pend_lo = idx == idx_pending_low;
  wire logic hit_pend_hi = idx == idx_pending_high;

  // unmapped addresses read as zero and swallow writes
  wire logic [31:0] read_mux =
    hit_third ? {24'h000000, irq_source_select_third} :
    hit_second ? {24'h000000, irq_source_select_second} :
    hit_first ? {24'h000000, irq_source_select_first} :
    hit_en ? {24'h000000, address_match_irq_enable} :
    hit_en_up ? {24'h000000, address_match_irq_enable_upper} :
    hit_cmp0 ? {8'h00, address_match_compare_0} :
    hit_cmp1 ? {8'h00, address_match_compare_1} :
    hit_cmp2 ? {8'h00, address_match_compare_2} :
    hit_cmp3 ? {8'h00, address_match_compare_3} :
    hit_pend_lo ? pending[31:0] :
    hit_pend_hi ? pending[63:32] : 32'h00000000;
  wire logic [31:0] merged = lanes(read_mux, writedata, byteenable);

  // one wait cycle per access keeps read data on a flip-flop
  assign waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (read && !bus_ack) begin
        readdata <= read_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_source_select_third <= reset_byte;
      irq_source_select_second <= reset_byte;
      irq_source_select_first <= reset_byte;
      address_match_irq_enable <= reset_byte;
      address_match_irq_enable_upper <= reset_byte;
    end else if (wr_go) begin
      if (hit_third) irq_source_select_third <= merged[7:0];
      if (hit_second) irq_source_select_second <= merged[7:0];
      if (hit_first) irq_source_select_first <= merged[7:0];
      if (hit_en) address_match_irq_enable <= merged[7:0];
      if (hit_en_up) address_match_irq_enable_upper <= merged[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      address_match_compare_0 <= reset_compare;
      address_match_compare_1 <= reset_compare;
      address_match_compare_2 <= reset_compare;
      address_match_compare_3 <= reset_compare;
    end else if (wr_go) begin
      if (hit_cmp0) address_match_compare_0 <= merged[23:0];
      if (hit_cmp1) address_match_compare_1 <= merged[23:0];
      if (hit_cmp2) address_match_compare_2 <= merged[23:0];
      if (hit_cmp3) address_match_compare_3 <= merged[23:0];
    end
  end

  // pins are idle high, so reset the chain high to avoid a false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_last <= 3'h7;
    end else begin
      pin_meta <= external_irq_pin_b;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  wire logic [2:0] pin_fall = pin_last & ~pin_sync;

  // source routing
  wire logic s7_cond = serial7_start_stop | serial7_collision;
  wire logic s7_tx = serial7_transmit | serial7_not_acknowledge;
  wire logic s0_cond = serial0_start_stop | serial0_collision;
  wire logic s1_cond = serial1_start_stop | serial1_collision;
  wire logic route_s7_cond =
    irq_source_select_second[sel_s7_cond] ? remote_control_0 : s7_cond;
  wire logic route_s7_tx =
    irq_source_select_second[sel_s7_tx] ? remote_control_1 : s7_tx;
  wire logic route_b3 =
    irq_source_select_second[sel_timer_b3] ? s0_cond : timer_b3;
  wire logic route_b4 =
    irq_source_select_second[sel_timer_b4] ? s1_cond : timer_b4;
  wire logic route_two_wire =
    irq_source_select_second[sel_two_wire] & two_wire_event;
  wire logic route_pin_level =
    irq_source_select_second[sel_pin_level] & two_wire_pin_level;

  // vectors 52..58 and all others left out here stay zero
  always_comb begin
    set_vec = '0;
    set_vec[vec_ext0] = pin_fall[0]; // [RL1]
    set_vec[vec_ext1] = pin_fall[1]; // [RL1]
    set_vec[vec_ext2] = pin_fall[2]; // [RL1]
    set_vec[vec_dma2] = dma2_done; // [RL2]
    set_vec[vec_dma3] = dma3_request; // [RL3]
    set_vec[vec_s5_cond] = serial5_start_stop | serial5_collision |
                           consumer_control_event_1; // [RL4]
    set_vec[vec_s5_tx] = serial5_transmit | serial5_not_acknowledge |
                         consumer_control_event_2; // [RL5]
    set_vec[vec_s5_rx] = serial5_receive | serial5_acknowledge; // [RL6]
    set_vec[vec_s6_cond] = serial6_start_stop | serial6_collision |
                           rtc_period; // [RL7]
    set_vec[vec_s6_tx] = serial6_transmit | serial6_not_acknowledge |
                         rtc_compare_match; // [RL8]
    set_vec[vec_s6_rx] = serial6_receive | serial6_acknowledge; // [RL9]
    set_vec[vec_s7_cond] = route_s7_cond; // [RL10] [RL16]
    set_vec[vec_s7_tx] = route_s7_tx; // [RL11] [RL17]
    set_vec[vec_s7_rx] = serial7_receive | serial7_acknowledge; // [RL12]
    set_vec[vec_two_wire] = route_two_wire; // [RL14] [RL20]
    set_vec[vec_pin_level] = route_pin_level; // [RL15] [RL20]
    set_vec[vec_timer_b3] = route_b3; // [RL18]
    set_vec[vec_timer_b4] = route_b4; // [RL19]
  end

  // an event landing on the acknowledge cycle re-arms its flag
  assign clr_vec = (irq_acknowledge && irq_request) ?
                   vec_set_type'(1) << irq_vector_number : '0;
  assign next_pending = (pending & ~clr_vec) | set_vec;
  assign pick.candidates = next_pending;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending <= '0;
      irq_request <= 1'b0;
      irq_vector_number <= '0;
      irq_vector_offset <= '0;
    end else begin
      pending <= next_pending;
      irq_request <= pick.found;
      irq_vector_number <= pick.number;
      irq_vector_offset <= vec_offset(pick.number); // [RL21]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_ext0_fall;
    pin_fall[0] |=> pending[vec_ext0] && irq_request;
  endproperty
  a_ext0_fall: assert property (p_ext0_fall) // [RL1]
    else $error("pin 0 falling edge did not raise vector 29");

  property p_dma2;
    dma2_done |=> pending[vec_dma2];
  endproperty
  a_dma2: assert property (p_dma2) // [RL2]
    else $error("dma2 completion lost");

  property p_s5_cond;
    consumer_control_event_1 |=> pending[vec_s5_cond];
  endproperty
  a_s5_cond: assert property (p_s5_cond) // [RL4]
    else $error("consumer event 1 did not raise vector 43");

  property p_s6_cond;
    rtc_period |=> pending[vec_s6_cond];
  endproperty
  a_s6_cond: assert property (p_s6_cond) // [RL7]
    else $error("clock period event did not raise vector 46");

  property p_remote0;
    irq_source_select_second[sel_s7_cond] && remote_control_0
      |=> pending[vec_s7_cond];
  endproperty
  a_remote0: assert property (p_remote0) // [RL16]
    else $error("remote control 0 not routed to vector 49");

  property p_s7_masked;
    irq_source_select_second[sel_s7_cond] && !remote_control_0 &&
      !pending[vec_s7_cond] |=> !pending[vec_s7_cond];
  endproperty
  a_s7_masked: assert property (p_s7_masked) // [RL10]
    else $error("deselected serial7 condition reached vector 49");

  property p_timer_b3;
    !irq_source_select_second[sel_timer_b3] && timer_b3
      |=> pending[vec_timer_b3];
  endproperty
  a_timer_b3: assert property (p_timer_b3) // [RL18]
    else $error("timer b3 not routed to its vector");

  property p_two_wire_off;
    !irq_source_select_second[sel_two_wire] && !pending[vec_two_wire]
      |=> !pending[vec_two_wire];
  endproperty
  a_two_wire_off: assert property (p_two_wire_off) // [RL20]
    else $error("disabled two-wire source raised vector 59");

  property p_soft_empty;
    pending[vec_soft_last:vec_soft_first] == '0;
  endproperty
  a_soft_empty: assert property (p_soft_empty) // [RL13]
    else $error("software-only vector set by hardware");

  property p_offset;
    irq_request |-> irq_vector_offset == vec_offset(irq_vector_number) &&
      pending[irq_vector_number];
  endproperty
  a_offset: assert property (p_offset) // [RL21]
    else $error("vector offset is not four times the number");

  property p_table;
    vec_offset(vec_ext0) == off_ext0 && vec_offset(vec_dma2) == off_dma2 &&
    vec_offset(vec_dma3) == off_dma3 &&
    vec_offset(vec_s5_cond) == off_s5_cond &&
    vec_offset(vec_s5_rx) == off_s5_rx &&
    vec_offset(vec_s6_cond) == off_s6_cond &&
    vec_offset(vec_s6_rx) == off_s6_rx &&
    vec_offset(vec_s7_cond) == off_s7_cond &&
    vec_offset(vec_s7_rx) == off_s7_rx &&
    vec_offset(vec_soft_last) == off_soft_last &&
    vec_offset(vec_two_wire) == off_two_wire &&
    vec_offset(vec_pin_level) == off_pin_level;
  endproperty
  a_table: assert property (p_table) // [RL21]
    else $error("vector table offset mismatch");

  property p_set_wins;
    irq_acknowledge && irq_request && set_vec[irq_vector_number]
      |=> pending[$past(irq_vector_number)];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost on acknowledge cycle");

  property p_bus_wait;
    bus_req && !bus_ack |-> waitrequest ##1 !waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not after exactly one wait cycle");

  c_ack: cover property (irq_request && irq_acknowledge);
  c_remote: cover property (route_s7_cond && remote_control_0);
  c_serial0: cover property (route_b3 && s0_cond);
  c_write: cover property (wr_go && hit_second);
endmodule

// ===== test/core_fetch_model.sv
// processor core model: takes the shown vector and acknowledges it
// assumes router outputs are registered on clk
`timescale 1ns/10ps
module core_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // vector request and answer
  input wire logic irq_request,
  input wire irq_route_pkg::vec_num_type irq_vector_number,
  input wire irq_route_pkg::vec_off_type irq_vector_offset,
  output logic irq_acknowledge,
  // pace and record for the bench
  input wire logic [1:0] ack_delay,
  output irq_route_pkg::vec_num_type taken_num,
  output irq_route_pkg::vec_off_type taken_off,
  output logic [15:0] taken_cnt
);
  import irq_route_pkg::*;
  logic [1:0] wait_cnt;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_acknowledge <= 1'b0;
      wait_cnt <= 2'h0;
      taken_cnt <= 16'h0;
    end else if (irq_acknowledge) begin
      // outputs still show the old vector on this edge, so never ack twice
      irq_acknowledge <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (irq_request && wait_cnt == ack_delay) begin
      irq_acknowledge <= 1'b1;
      taken_num <= irq_vector_number;
      taken_off <= irq_vector_offset;
      taken_cnt <= taken_cnt + 16'h1;
    end else begin
      wait_cnt <= irq_request ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== test/testbench.sv
// self-checking bench for the interrupt vector router
// assumes the core model answers every request it sees
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("mismatch %s expected %h seen %h", nm, e, g); fails++; end end
module testbench;
  import irq_route_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] address = 12'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [2:0] pin_b = 3'h7;
  logic [33:0] ev = 34'h0;
  logic irq_request;
  logic irq_acknowledge;
  vec_num_type irq_vector_number;
  vec_num_type taken_num;
  vec_off_type irq_vector_offset;
  vec_off_type taken_off;
  logic [15:0] taken_cnt;
  logic [1:0] ack_delay = 2'h0;
  logic [31:0] seed = 32'h3ca9;
  int fails = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  irq_vector_router irq_vector_router_i (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .external_irq_pin_b(pin_b), .dma2_done(ev[0]), .dma3_request(ev[1]),
    .serial5_start_stop(ev[2]), .serial5_collision(ev[3]),
    .serial5_transmit(ev[4]), .serial5_not_acknowledge(ev[5]),
    .serial5_receive(ev[6]), .serial5_acknowledge(ev[7]),
    .consumer_control_event_1(ev[8]), .consumer_control_event_2(ev[9]),
    .serial6_start_stop(ev[10]), .serial6_collision(ev[11]),
    .serial6_transmit(ev[12]), .serial6_not_acknowledge(ev[13]),
    .serial6_receive(ev[14]), .serial6_acknowledge(ev[15]),
    .rtc_period(ev[16]), .rtc_compare_match(ev[17]),
    .serial7_start_stop(ev[18]), .serial7_collision(ev[19]),
    .serial7_transmit(ev[20]), .serial7_not_acknowledge(ev[21]),
    .serial7_receive(ev[22]), .serial7_acknowledge(ev[23]),
    .remote_control_0(ev[24]), .remote_control_1(ev[25]),
    .two_wire_event(ev[26]), .two_wire_pin_level(ev[27]),
    .timer_b3(ev[28]), .timer_b4(ev[29]), .serial0_start_stop(ev[30]),
    .serial0_collision(ev[31]), .serial1_start_stop(ev[32]),
    .serial1_collision(ev[33]), .irq_request(irq_request),
    .irq_vector_number(irq_vector_number),
    .irq_vector_offset(irq_vector_offset),
    .irq_acknowledge(irq_acknowledge));
  core_fetch_model core_fetch_model_i (
    .clk(clk), .rst_b(rst_b), .irq_request(irq_request),
    .irq_vector_number(irq_vector_number),
    .irq_vector_offset(irq_vector_offset),
    .irq_acknowledge(irq_acknowledge), .ack_delay(ack_delay),
    .taken_num(taken_num), .taken_off(taken_off), .taken_cnt(taken_cnt));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // vector an event lands on under select byte s, -1 when routed away
  function automatic int exp_vec(int i, logic [7:0] s);
    int t[34] = '{41, 42, 43, 43, 44, 44, 45, 45, 43, 44, 46, 46, 47, 47,
      48, 48, 46, 47, 49, 49, 50, 50, 51, 51, 49, 50, 59, 60, 7, 6, 7, 7,
      6, 6};
    case (i)
      18, 19: if (s[4]) return -1;
      20, 21: if (s[5]) return -1;
      24: if (!s[4]) return -1;
      25: if (!s[5]) return -1;
      26: if (!s[2]) return -1;
      27: if (!s[3]) return -1;
      28, 30, 31: if (s[6] != (i > 28)) return -1;
      29, 32, 33: if (s[7] != (i > 29)) return -1;
      default: ;
    endcase
    return t[i];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang(string nm);
    $display("mismatch %s expected answer seen none", nm);
    fails++;
    report_and_stop();
  endtask
  // request stands until the rising edge that sees waitrequest low;
  // that edge lands the write and is where read data is taken
  task automatic bus(logic wr, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) hang("bus");
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic expect_take(int v);
    int k;
    logic [15:0] c0;
    c0 = taken_cnt;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if (taken_cnt !== c0) break;
    end
    if (k == 40) hang("vector request");
    `CHK("vector number", v[5:0], taken_num)
    `CHK("vector offset", 8'(v * 4), taken_off)
  endtask
  task automatic quiet();
    logic [15:0] c0;
    c0 = taken_cnt;
    repeat (8) @(negedge clk);
    `CHK("extra takes", c0, taken_cnt)
    `CHK("request idle", 1'b0, irq_request)
  endtask
  task automatic round(logic [7:0] s, logic [33:0] m);
    logic [31:0] q;
    logic [63:0] want;
    int v;
    want = 64'h0;
    bus(1'b1, 12'h818, {24'h0, s}, q);
    for (int i = 0; i < 34; i++) begin
      v = exp_vec(i, s);
      if (m[i] && v >= 0) want[v] = 1'b1;
    end
    ack_delay <= 2'(rnd());
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 34'h0;
    // all set on one edge, so the core must see lowest number first
    for (v = 0; v < 64; v++)
      if (want[v]) expect_take(v);
    quiet();
  endtask
  initial begin
    logic [31:0] q;
    logic [31:0] d;
    logic [11:0] ra[9];
    ra = '{12'h814, 12'h818, 12'h81c, 12'h838, 12'h83c, 12'h840, 12'h850,
      12'h860, 12'h870};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0, q);
      `CHK("reset value", 32'h0, q)
      d = rnd();
      bus(1'b1, ra[i], d, q);
      bus(1'b0, ra[i], 32'h0, q);
      `CHK("readback", d & (i < 5 ? 32'hff : 32'hffffff), q)
    end
    bus(1'b1, 12'h800, 32'hffffffff, q);
    bus(1'b0, 12'h800, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, 12'h880, 32'hffffffff, q);
    bus(1'b0, 12'h880, 32'h0, q);
    `CHK("pending read only", 32'h0, q)
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      pin_b[k] <= 1'b0;
      expect_take(29 + k);
      @(posedge clk);
      pin_b[k] <= 1'b1;
      quiet();
    end
    $display("test pins done");
    // event held into its own acknowledge cycle: set wins, vector returns
    @(posedge clk);
    ev <= 34'h1;
    expect_take(41);
    @(posedge clk);
    ev <= 34'h0;
    expect_take(41);
    quiet();
    $display("test set wins done");
    round(8'h00, '1);
    round(8'hff, '1);
    for (int r = 0; r < 40; r++)
      round(8'(rnd()), 34'h1 << (rnd() % 34) | 34'h1 << (rnd() % 34));
    $display("test routing done");
    report_and_stop();
  end
endmodule
